// >>> core/cso_pkg.sv
package cso_pkg;
  // option field layout (16-bit option word)
  localparam int OPT_MODE = 15;
  localparam int OPT_BYTE_HI = 14;
  localparam int OPT_BYTE_LO = 13;
  localparam int OPT_RW_HI = 12;
  localparam int OPT_RW_LO = 11;
  localparam int OPT_STROBE = 10;
  localparam int OPT_ACK_HI = 9;
  localparam int OPT_ACK_LO = 6;
  localparam int OPT_SPACE_HI = 5;
  localparam int OPT_SPACE_LO = 4;
  localparam int OPT_LVL_HI = 3;
  localparam int OPT_LVL_LO = 1;
  localparam int OPT_AUTOVEC = 0;

  localparam logic [1:0] BYTE_OFF = 2'h0;
  localparam logic [1:0] BYTE_LOWER = 2'h1;
  localparam logic [1:0] BYTE_UPPER = 2'h2;
  localparam logic [1:0] BYTE_BOTH = 2'h3;

  localparam logic [1:0] RW_RSVD = 2'h0;
  localparam logic [1:0] RW_READ = 2'h1;
  localparam logic [1:0] RW_WRITE = 2'h2;
  localparam logic [1:0] RW_BOTH = 2'h3;

  localparam logic [1:0] SP_CPU = 2'h0;
  localparam logic [1:0] SP_USER = 2'h1;
  localparam logic [1:0] SP_SUPV = 2'h2;
  localparam logic [1:0] SP_SU = 2'h3;

  // function codes
  localparam logic [2:0] FC_USER_DATA = 3'h1;
  localparam logic [2:0] FC_USER_PROG = 3'h2;
  localparam logic [2:0] FC_SUPV_DATA = 3'h5;
  localparam logic [2:0] FC_SUPV_PROG = 3'h6;
  localparam logic [2:0] FC_CPU = 3'h7;

  localparam logic [3:0] ACK_WAIT_MAX = 4'hD;
  localparam logic [3:0] ACK_FAST = 4'hE;
  localparam logic [3:0] ACK_EXTERNAL = 4'hF;
  localparam logic [2:0] LEVEL_ANY = 3'h0;
  localparam logic [3:0] ACK_NO_WAIT = 4'h0;
  localparam logic [3:0] WAIT_LAST = 4'h1;
  localparam logic [3:0] WAIT_STEP = 4'h1;
  localparam logic [3:0] WAIT_CLEAR = 4'h0;

  // pin assignment code for a 16-bit chip-select
  localparam logic [1:0] PIN_CS16 = 2'h3;
  localparam logic [1:0] PIN_CS8 = 2'h2;

  typedef struct packed {
    logic start;
    logic as_valid;
    logic ds_valid;
    logic read;
    logic [2:0] fc;
    logic [2:0] irq_level;
    logic upper_lane;
    logic lower_lane;
    logic addr_match;
  } cso_cycle_t;

  typedef struct packed {
    logic sync_mode;
    logic [1:0] byte_lane;
    logic [1:0] direction;
    logic strobe_select;
    logic [3:0] ack_code;
    logic [1:0] space;
    logic [2:0] level;
    logic autovector_select;
  } cso_option_t;

  typedef enum logic [1:0] {
    CSO_IDLE = 2'b00,
    CSO_WAIT = 2'b01,
    CSO_EXT = 2'b10,
    CSO_DONE = 2'b11
  } cso_state_t;
endpackage

// >>> core/cso_decode.sv
`timescale 1ns/10ps
// Overview of operation
// - byte field: 00 off, 01 lower, 10 upper, 11 either byte lane
// - byte qualification applies only when pins assign a 16-bit chip-select
// - direction field: 01 read, 10 write, 11 both; 00 reserved, never asserts
// - async: strobe bit 1 aligns with data strobe, 0 with address strobe
// - async ack codes 0 to 13 terminate internally after that many waits
// - ack 1110 fast termination; 1111 waits for external data-size acknowledge
// - space field compares function code: cpu, user, supervisor, either
// - in acknowledge cycles level taken from address lines three to one
// - level must equal programmed level; 000 matches any level
// - autovector bit requests autovector on matching async acknowledge; else external vector
// - mode bit set selects synchronous, clear asynchronous operation
module cso_decode (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // configuration
  input wire logic [15:0] option_word,
  input wire logic [1:0] pin_assign,
  // cpu bus cycle
  input wire cso_pkg::cso_cycle_t cycle,
  input wire logic [3:1] addr_low,
  input wire logic ext_ack,
  // outputs
  output logic chip_select,
  output logic cycle_match,
  output logic data_size_acknowledge,
  output logic fast_term,
  output logic autovector_req,
  output logic waiting_external,
  output logic interrupt_acknowledge_cycle
);
  cso_pkg::cso_option_t opt;
  cso_pkg::cso_state_t state;
  cso_pkg::cso_state_t next_state;
  logic [3:0] wait_cnt;
  logic [3:0] next_wait_cnt;
  logic lane_ok;
  logic dir_ok;
  logic space_ok;
  logic interrupt_level_match;
  logic qualify;
  logic strobe_ok;
  logic user_space;
  logic supervisor_space;
  logic cpu_space;
  logic take_cycle;
  logic take_autovector;
  logic take_fast;
  logic take_external;
  logic take_no_wait;
  logic take_wait;
  logic wait_done;
  logic external_done;
  logic cycle_released;

  assign opt = cso_pkg::cso_option_t'(option_word);
  assign interrupt_acknowledge_cycle = (cycle.fc == cso_pkg::FC_CPU);

  always_comb begin
    lane_ok = 1'b1;
    if (pin_assign == cso_pkg::PIN_CS16) begin
      case (opt.byte_lane)
        cso_pkg::BYTE_OFF: lane_ok = 1'b0;
        cso_pkg::BYTE_LOWER: lane_ok = cycle.lower_lane;
        cso_pkg::BYTE_UPPER: lane_ok = cycle.upper_lane;
        cso_pkg::BYTE_BOTH: lane_ok = cycle.lower_lane | cycle.upper_lane;
        default: lane_ok = 1'b0;
      endcase
    end
  end

  always_comb begin
    case (opt.direction)
      cso_pkg::RW_READ: dir_ok = cycle.read;
      cso_pkg::RW_WRITE: dir_ok = ~cycle.read;
      cso_pkg::RW_BOTH: dir_ok = 1'b1;
      cso_pkg::RW_RSVD: dir_ok = 1'b0; // reserved code never selects
      default: dir_ok = 1'b0;
    endcase
  end

  // function code classes shared by the space decode
  assign user_space = (cycle.fc == cso_pkg::FC_USER_DATA) ||
                      (cycle.fc == cso_pkg::FC_USER_PROG);
  assign supervisor_space = (cycle.fc == cso_pkg::FC_SUPV_DATA) ||
                            (cycle.fc == cso_pkg::FC_SUPV_PROG);
  assign cpu_space = (cycle.fc == cso_pkg::FC_CPU);

  always_comb begin
    case (opt.space)
      cso_pkg::SP_CPU: space_ok = cpu_space;
      cso_pkg::SP_USER: space_ok = user_space;
      cso_pkg::SP_SUPV: space_ok = supervisor_space;
      cso_pkg::SP_SU: space_ok = user_space | supervisor_space;
      default: space_ok = 1'b0;
    endcase
  end

  // level check only gates acknowledge cycles; ordinary cycles pass
  assign interrupt_level_match = ~interrupt_acknowledge_cycle ||
                                 (opt.level == cso_pkg::LEVEL_ANY) ||
                                 (opt.level == addr_low);

  assign qualify = cycle.addr_match & lane_ok & dir_ok & space_ok &
                   interrupt_level_match;

  // sync mode follows address strobe; async picks strobe by option bit
  assign strobe_ok = opt.sync_mode ? cycle.as_valid :
                     (opt.strobe_select ? cycle.ds_valid : cycle.as_valid);

  assign cycle_match = qualify;

  // chip-select registered so it is glitch free on the pin
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      chip_select <= 1'b0;
    end else begin
      chip_select <= qualify & strobe_ok;
    end
  end

  // a bus cycle is taken only while idle; sync mode never answers internally
  assign take_cycle = cycle.start && qualify && !opt.sync_mode &&
                      (state == cso_pkg::CSO_IDLE);
  // a matching acknowledge cycle with autovector wins over any ack code
  assign take_autovector = take_cycle && interrupt_acknowledge_cycle &&
                           opt.autovector_select;
  assign take_fast = take_cycle && !take_autovector &&
                     (opt.ack_code == cso_pkg::ACK_FAST);
  assign take_external = take_cycle && !take_autovector &&
                         (opt.ack_code == cso_pkg::ACK_EXTERNAL);
  assign take_no_wait = take_cycle && !take_autovector &&
                        (opt.ack_code == cso_pkg::ACK_NO_WAIT);
  assign take_wait = take_cycle && !take_autovector &&
                     (opt.ack_code > cso_pkg::ACK_NO_WAIT) &&
                     (opt.ack_code <= cso_pkg::ACK_WAIT_MAX);

  // the last wait state is the one in which the count stands at one
  assign wait_done = (state == cso_pkg::CSO_WAIT) &&
                     (wait_cnt == cso_pkg::WAIT_LAST);
  // a dropped address strobe ends an external wait so a lost device cannot hang the bus
  assign external_done = ext_ack || !cycle.as_valid;
  assign cycle_released = !cycle.as_valid;

  always_comb begin
    next_state = state;
    case (state)
      cso_pkg::CSO_IDLE: begin
        if (take_autovector || take_fast || take_no_wait) begin
          next_state = cso_pkg::CSO_DONE;
        end else if (take_external) begin
          next_state = cso_pkg::CSO_EXT;
        end else if (take_wait) begin
          next_state = cso_pkg::CSO_WAIT;
        end
      end
      cso_pkg::CSO_WAIT: begin
        if (wait_done) begin
          next_state = cso_pkg::CSO_DONE;
        end
      end
      cso_pkg::CSO_EXT: begin
        if (external_done) begin
          next_state = cso_pkg::CSO_DONE;
        end
      end
      cso_pkg::CSO_DONE: begin
        // hold until the cpu drops the strobe so one cycle gets one answer
        if (cycle_released) begin
          next_state = cso_pkg::CSO_IDLE;
        end
      end
      default: begin
        next_state = cso_pkg::CSO_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= cso_pkg::CSO_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // wait counter loads the programmed count and runs down to zero
  always_comb begin
    next_wait_cnt = wait_cnt;
    if (take_wait) begin
      next_wait_cnt = opt.ack_code;
    end else if (state == cso_pkg::CSO_WAIT) begin
      next_wait_cnt = wait_cnt - cso_pkg::WAIT_STEP;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wait_cnt <= cso_pkg::WAIT_CLEAR;
    end else begin
      wait_cnt <= next_wait_cnt;
    end
  end

  // internal termination pulse, one cycle wide
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      data_size_acknowledge <= 1'b0;
    end else begin
      data_size_acknowledge <= take_no_wait || wait_done;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fast_term <= 1'b0;
    end else begin
      fast_term <= take_fast;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      autovector_req <= 1'b0;
    end else begin
      autovector_req <= take_autovector;
    end
  end

  assign waiting_external = (state == cso_pkg::CSO_EXT);
endmodule

// >>> bench/cso_ext_dev.sv
`timescale 1ns/10ps
module cso_ext_dev (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // acknowledge handshake
  input wire logic waiting_external,
  input wire logic [3:0] delay,
  output logic ext_ack
);
  logic [3:0] cnt;
  // ack only inside a wait, so a stale ack can never end the next cycle early
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt <= 4'h0;
      ext_ack <= 1'b0;
    end else begin
      cnt <= waiting_external ? cnt + 4'h1 : 4'h0;
      ext_ack <= waiting_external && cnt >= delay;
    end
  end
endmodule

// >>> bench/cso_decode_checker.sv
`timescale 1ns/10ps
module cso_decode_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // watched ports
  input wire logic [15:0] option_word,
  input wire logic [1:0] pin_assign,
  input wire cso_pkg::cso_cycle_t cycle,
  input wire logic [3:1] addr_low,
  input wire logic chip_select,
  input wire logic cycle_match,
  input wire logic data_size_acknowledge,
  input wire logic fast_term,
  input wire logic autovector_req,
  input wire logic waiting_external,
  input wire logic interrupt_acknowledge_cycle
);
  wire [15:0] o = option_word;
  wire m = cycle_match;
  wire av = interrupt_acknowledge_cycle && o[0];
  wire go = cycle.start && m && !o[15];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  cs_follow_a: assert property (
    !$past(rst) |-> chip_select ==
    $past(m && ((o[15] || !o[10]) ? cycle.as_valid : cycle.ds_valid))) else $error("cs lag");
  byte_off_a: assert property (
    pin_assign == 2'h3 && o[14:13] == 2'h0 |-> !m) else $error("byte");
  dir_gate_a: assert property (
    m |-> cycle.addr_match && (cycle.read ? o[11] : o[12])) else $error("dir");
  space_gate_a: assert property (
    m |-> (cycle.fc == 3'h7 ? o[5:4] == 2'h0 : cycle.fc[2] ? o[5] : o[4])) else $error("space");
  level_gate_a: assert property (
    m && interrupt_acknowledge_cycle |-> o[3:1] == 3'h0 || o[3:1] == addr_low) else $error("lvl");
  zero_wait_a: assert property (
    $rose(cycle.as_valid) && go && !av && o[9:6] == 4'h0 |=> data_size_acknowledge)
    else $error("wait0");
  max_wait_a: assert property (
    $rose(cycle.as_valid) && go && !av && o[9:6] == 4'hD |-> ##14 data_size_acknowledge)
    else $error("wait13");
  autovector_resp_a: assert property (
    $rose(cycle.as_valid) && go && av |=> autovector_req) else $error("autovector");
  fast_term_a: assert property (
    $rose(cycle.as_valid) && go && !av && o[9:6] == 4'hE |=> fast_term) else $error("fast");
  ext_wait_a: assert property (
    $rose(cycle.as_valid) && go && !av && o[9:6] == 4'hF |=> waiting_external)
    else $error("external wait");
  ack_decode_a: assert property (
    interrupt_acknowledge_cycle == (cycle.fc == 3'h7)) else $error("ack cycle");
endmodule
bind cso_decode cso_decode_checker i_chk (.clk_sys, .rst, .option_word, .pin_assign, .cycle,
  .addr_low, .chip_select, .cycle_match, .data_size_acknowledge, .fast_term, .autovector_req,
  .waiting_external, .interrupt_acknowledge_cycle);

// >>> bench/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [15:0] option_word = 16'h0;
  logic [1:0] pin_assign = 2'h2;
  cso_pkg::cso_cycle_t cycle = '0;
  logic [3:1] addr_low = 3'h0;
  logic [3:0] delay = 4'h2;
  logic ext_ack, chip_select, cycle_match, size_ack, fast_term, autovec, waiting, ack_cyc, e;
  logic [31:0] r;
  int errors = 0;
  int checks = 0;
  int seed = 32'h3CA4DDAE;
  int k;
  logic [2:0] fcs [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
  cso_decode i_dut (.clk_sys, .rst, .option_word, .pin_assign, .cycle, .addr_low, .ext_ack,
    .chip_select, .cycle_match, .data_size_acknowledge(size_ack), .fast_term,
    .autovector_req(autovec), .waiting_external(waiting), .interrupt_acknowledge_cycle(ack_cyc));
  cso_ext_dev i_dev (.clk_sys, .rst, .waiting_external(waiting), .delay, .ext_ack);
  initial forever #4 clk_sys = ~clk_sys;
  task chk(string n, logic [4:0] s, logic [4:0] x);
    checks++;
    if (s !== x) begin
      errors++;
      $display("CHECK FAILED %s expected %0d seen %0d", n, x, s);
    end
  endtask
  task complete_run;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function logic qual(logic [15:0] o, logic [1:0] p, cso_pkg::cso_cycle_t c, logic [3:1] a);
    qual = (p != 2'h3 || |(o[14:13] & {c.upper_lane, c.lower_lane})) && c.addr_match &&
      (c.read ? o[11] : o[12]) && (c.fc == 3'h7 ?
      o[5:4] == 2'h0 && (o[3:1] == 3'h0 || o[3:1] == a) : c.fc[2] ? o[5] : o[4]);
  endfunction
  // one acknowledge cycle in cpu space; as_valid held until the answer, then dropped
  task run(logic [15:0] o, logic [4:0] lat, logic [2:0] kind);
    @(posedge clk_sys);
    option_word <= o;
    cycle <= {7'h7F, 3'h0, 3'h7};
    @(posedge clk_sys);
    cycle.start <= 1'b0;
    // k = 1 is just after the edge that takes the start; pulses stand one cycle only
    for (k = 1; k <= 30; k++) begin
      #1;
      if (k == 1) chk("wait", waiting, o[9:6] == 4'hF);
      if (size_ack || fast_term || autovec || (o[9:6] == 4'hF && !waiting)) break;
      @(posedge clk_sys);
    end
    if (k > 30) begin
      errors++;
      complete_run;
    end
    chk("latency", 5'(k), lat);
    if (o[9:6] != 4'hF) chk("kind", {autovec, fast_term, size_ack}, kind);
    @(posedge clk_sys);
    cycle <= '0;
    repeat (2) @(posedge clk_sys);
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    for (int n = 0; n < 16; n++) begin
      // external latency is the partner delay plus three
      run({5'h0F, 1'b0, 4'(n), 6'h0}, n < 14 ? 5'(n + 1) : n == 14 ? 5'h1 : 5'h5,
        n < 14 ? 3'h1 : 3'h2);
    end
    run({5'h0F, 1'b0, 4'hE, 6'h1}, 5'h1, 3'h4);
    delay <= 4'h9;
    run({5'h0F, 1'b0, 4'hF, 6'h0}, 5'hC, 3'h0);
    for (int i = 0; i < 400; i++) begin
      @(posedge clk_sys);
      r = $random(seed);
      option_word <= r[15:0];
      addr_low <= r[18:16];
      pin_assign <= r[20:19];
      cycle <= {1'b0, r[21], r[22], r[23], fcs[r[26:24] % 5], 3'h0, r[27], !r[27], |r[29:28]};
      @(negedge clk_sys);
      e = qual(option_word, pin_assign, cycle, addr_low);
      chk("match", cycle_match, e);
      chk("ack cycle", ack_cyc, cycle.fc == 3'h7);
      e = e && ((option_word[15] || !option_word[10]) ? cycle.as_valid : cycle.ds_valid);
      @(posedge clk_sys);
      #1;
      chk("cs", chip_select, e);
    end
    complete_run;
  end
endmodule
